// ==== hw/psq_pkg.sv ====
// Package of constants and types for the pattern sequencer
package psq_pkg;
    localparam int PODS_MAX = 3;              // Pods at full expansion
    localparam int POD_CH = 12;               // Channels per pod
    localparam int CH_MAX = PODS_MAX * POD_CH; // Thirty-six channels
    localparam int SER = 4;                   // Serial bits per channel per word
    localparam int WORD_W = CH_MAX * SER;     // Parallel pattern word width
    localparam int PAT_AW = 8;                // Pattern memory address width
    localparam int SEQ_AW = 4;                // Sequence memory address width
    localparam int REP_W = 16;                // Repeat count width
    localparam int DIV_W = 32;                // Point-rate divider width
    localparam int DLY_W = 3;                 // Delay tap select width
    localparam int DLY_CH_LO = 8;             // First delayed pod channel
    localparam int DLY_CH_HI = 11;            // Last delayed pod channel
    localparam int CLK_PS = 5000;             // Clock period in ps
    localparam int DLY_MAX_PS = 20000;        // Longest delay, 20 ns
    localparam int DLY_TAPS = DLY_MAX_PS / CLK_PS; // Delay taps, rounded down
    localparam logic [SEQ_AW-1:0] SEQ_FIRST = 4'h0; // First sequence entry
    localparam logic [1:0] POD_ONE = 2'h1;    // Twelve channels
    localparam logic [1:0] POD_TWO = 2'h2;    // Twenty-four channels
    localparam logic [1:0] POD_THREE = 2'h3;  // Thirty-six channels

    // One sequence entry: segment bounds and repeat count
    typedef struct packed {
        logic [PAT_AW-1:0] seg_start;
        logic [PAT_AW-1:0] seg_end;
        logic [REP_W-1:0] reps;
        logic last;
    } psq_entry_t;

    // Sequencer states
    typedef enum logic [1:0] {
        PSQ_IDLE = 2'b00,
        PSQ_ARM = 2'b01,
        PSQ_RUN = 2'b10
    } psq_state_t;
endpackage

// ==== hw/psq_buf_if.sv ====
// Valid/ready carrier between sequencer and output stage
`timescale 1ns/1ps
`default_nettype none
interface psq_buf_if;
    logic valid; // Word offered
    logic ready; // Word accepted
    logic [psq_pkg::WORD_W-1:0] data; // Pattern word
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== hw/psq_buf2.sv ====
// Two-entry buffer between pattern read and shift register
`timescale 1ns/1ps
`default_nettype none
module psq_buf2 (
    input wire logic sys_clk,
    input wire logic sys_rst,
    psq_buf_if.snk in_p,
    psq_buf_if.src out_p
);
    logic [psq_pkg::WORD_W-1:0] mem [2]; // Storage
    logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr; // Pointers
    logic [1:0] cnt, next_cnt; // Fill level
    logic push, pop; // Transfers

    // Honest full and empty flags
    assign in_p.ready = (cnt != 2'h2);
    assign out_p.valid = (cnt != 2'h0);
    assign out_p.data = mem[rd_ptr];
    assign push = in_p.valid && in_p.ready;
    assign pop = out_p.valid && out_p.ready;

    // Next pointers and count
    always_comb begin
        next_wr_ptr = push ? ~wr_ptr : wr_ptr;
        next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
        next_cnt = cnt + {1'b0, push} - {1'b0, pop};
    end

    // Register state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            cnt <= 2'h0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            cnt <= next_cnt;
        end
        if (push) begin
            mem[wr_ptr] <= in_p.data;
        end
    end

    AST_BUF_NO_OVER: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cnt <= 2'h2) else $error("Buffer count overflow");

    AST_BUF_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (out_p.valid && !out_p.ready) |=> (out_p.valid && $stable(out_p.data)))
        else $error("Buffer dropped a stalled word");
endmodule
`default_nettype wire

// ==== hw/psq_top.sv ====
// Pattern sequencer: sequence walk, point clock, buffer, serialiser, delay
`timescale 1ns/1ps
`default_nettype none
module psq_top (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic start, // Start pulse
    input wire logic stop, // Stop pulse
    input wire logic continuous, // Repeat run mode
    input wire logic pll_on, // Phase lock enabled
    input wire logic trig_pin, // External trigger pin
    input wire logic trig_fall, // Trigger on falling slope
    input wire logic [psq_pkg::DIV_W-1:0] div_ratio, // Cycles per point
    input wire logic [1:0] pod_count, // Pods fitted
    input wire logic [psq_pkg::DLY_W-1:0] dly_sel [psq_pkg::PODS_MAX*4], // Delay taps
    input wire logic pat_we, // Pattern write strobe
    input wire logic [psq_pkg::PAT_AW-1:0] pat_waddr, // Pattern write address
    input wire logic [psq_pkg::WORD_W-1:0] pat_wdata, // Pattern write data
    input wire logic seq_we, // Sequence write strobe
    input wire logic [psq_pkg::SEQ_AW-1:0] seq_waddr, // Sequence write address
    input wire psq_pkg::psq_entry_t seq_wdata, // Sequence entry
    output logic [psq_pkg::CH_MAX-1:0] pod_out, // Channel outputs
    output logic running // Sequencer active
);
    // Local copies of package sizes
    localparam int CH_MAX = psq_pkg::CH_MAX; // Channel count
    localparam int POD_CH = psq_pkg::POD_CH; // Channels per pod
    localparam int WORD_W = psq_pkg::WORD_W; // Pattern word width
    localparam int PAT_AW = psq_pkg::PAT_AW; // Pattern address width
    localparam int SEQ_AW = psq_pkg::SEQ_AW; // Sequence address width
    localparam int REP_W = psq_pkg::REP_W; // Repeat count width
    localparam int DIV_W = psq_pkg::DIV_W; // Divider width
    localparam int DLY_W = psq_pkg::DLY_W; // Delay select width
    localparam int DLY_TAPS = psq_pkg::DLY_TAPS; // Delay taps
    localparam int DLY_N = psq_pkg::DLY_CH_HI - psq_pkg::DLY_CH_LO + 1; // Delayed lanes per pod
    localparam int SHL_W = $clog2(psq_pkg::SER + 1); // Slice counter width

    // Memories
    logic [WORD_W-1:0] pat_mem [2**PAT_AW]; // Pattern words
    psq_pkg::psq_entry_t seq_mem [2**SEQ_AW]; // Sequence program

    // Trigger synchroniser
    logic [2:0] trig_s, next_trig_s; // Three sync stages
    logic trig_lvl, next_trig_lvl; // Agreed trigger level
    logic trig_lvl_d, next_trig_lvl_d; // Previous agreed level
    logic trig_hit; // Selected slope seen

    // Point clock divider
    logic [DIV_W-1:0] div_cnt, next_div_cnt; // Cycles into point
    logic [DIV_W-1:0] div_last; // Last cycle of a point
    logic tick_en; // Point clock allowed
    logic tick; // One point ends

    // Sequence walk
    psq_pkg::psq_state_t state, next_state; // Sequencer state
    logic [SEQ_AW-1:0] seq_idx, next_seq_idx; // Current entry
    logic [SEQ_AW-1:0] seq_nxt; // Entry after this one
    logic [PAT_AW-1:0] pat_addr, next_pat_addr; // Word to fetch
    logic [REP_W-1:0] rep_cnt, next_rep_cnt; // Passes done
    psq_pkg::psq_entry_t cur; // Current entry contents
    logic at_end; // Last word of segment
    logic rep_done; // Last pass of entry
    logic list_end; // Last entry of program
    logic issue; // Fetch a word now

    // Fetch stage feeding the buffer
    logic fetch_valid, next_fetch_valid; // Word held
    logic [WORD_W-1:0] fetch_data, next_fetch_data; // Fetched word

    // Output stage
    logic [WORD_W-1:0] shift_reg, next_shift_reg; // Unsent slices
    logic [SHL_W-1:0] shift_left, next_shift_left; // Slices left
    logic [CH_MAX-1:0] col, next_col; // Column on show
    logic col_live, next_col_live; // Column holds data
    logic [CH_MAX-1:0] col_m; // Column after pod mask
    logic [CH_MAX-1:0] next_pod_out; // Column after delay
    logic [1:0] pods_on; // Pods in use
    logic busy; // Work still in flight

    // Carriers around the two-entry buffer
    psq_buf_if fetch_if (); // Fetch to buffer
    psq_buf_if play_if (); // Buffer to serialiser

    always_ff @(posedge sys_clk) begin
        if (seq_we) begin
            seq_mem[seq_waddr] <= seq_wdata;
        end
        if (pat_we) begin
            pat_mem[pat_waddr] <= pat_wdata;
        end
    end

    assign trig_hit = trig_fall ? (trig_lvl_d && !trig_lvl) : (!trig_lvl_d && trig_lvl);

    // Synchroniser next values; level moves once stages two and three agree
    always_comb begin
        next_trig_s = {trig_s[1:0], trig_pin};
        next_trig_lvl = (trig_s[1] == trig_s[2]) ? trig_s[2] : trig_lvl;
        next_trig_lvl_d = trig_lvl;
    end

    // Synchroniser registers; reset level matches an idle low pin
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            trig_s <= 3'h0;
            trig_lvl <= 1'b0;
            trig_lvl_d <= 1'b0;
        end else begin
            trig_s <= next_trig_s;
            trig_lvl <= next_trig_lvl;
            trig_lvl_d <= next_trig_lvl_d;
        end
    end

    assign div_last = (div_ratio == '0) ? '0 : div_ratio - 32'h1;
    assign tick_en = (state == psq_pkg::PSQ_RUN) || ((state == psq_pkg::PSQ_IDLE) && busy);
    assign tick = tick_en && (div_cnt == div_last);

    // Divider next value; held at zero while gated
    always_comb begin
        next_div_cnt = (!tick_en || tick) ? '0 : div_cnt + 32'h1;
    end

    // Divider register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    // Work in flight keeps the flag up until the last column ends
    assign busy = (state != psq_pkg::PSQ_IDLE) || fetch_valid || play_if.valid
        || (shift_left != '0) || col_live;

    // Walk conditions for the current entry
    assign cur = seq_mem[seq_idx];
    assign at_end = (pat_addr == cur.seg_end);
    assign rep_done = ((rep_cnt + 16'h1) >= cur.reps);
    assign list_end = cur.last || (seq_idx == '1);
    assign seq_nxt = list_end ? psq_pkg::SEQ_FIRST : seq_idx + 4'h1;
    assign issue = (state == psq_pkg::PSQ_RUN) && (!fetch_valid || fetch_if.ready);

    // Sequencer next values
    always_comb begin
        next_state = state;
        next_seq_idx = seq_idx;
        next_pat_addr = pat_addr;
        next_rep_cnt = rep_cnt;
        case (state)
            psq_pkg::PSQ_IDLE: begin
                // Start only once the last run has drained
                if (start && !busy) begin
                    next_seq_idx = psq_pkg::SEQ_FIRST;
                    next_pat_addr = seq_mem[psq_pkg::SEQ_FIRST].seg_start;
                    next_rep_cnt = '0;
                    next_state = pll_on ? psq_pkg::PSQ_RUN : psq_pkg::PSQ_ARM;
                end
            end
            psq_pkg::PSQ_ARM: begin
                if (stop) begin
                    next_state = psq_pkg::PSQ_IDLE;
                end else if (trig_hit) begin
                    next_state = psq_pkg::PSQ_RUN;
                end
            end
            psq_pkg::PSQ_RUN: begin
                if (stop) begin
                    next_state = psq_pkg::PSQ_IDLE;
                end else if (issue) begin
                    if (!at_end) begin
                        // Next word of segment
                        next_pat_addr = pat_addr + 8'h1;
                    end else if (!rep_done) begin
                        // Replay the same segment
                        next_rep_cnt = rep_cnt + 16'h1;
                        next_pat_addr = cur.seg_start;
                    end else begin
                        // Move to the following entry
                        next_rep_cnt = '0;
                        next_seq_idx = seq_nxt;
                        next_pat_addr = seq_mem[seq_nxt].seg_start;
                        if (list_end && !continuous) begin
                            next_state = psq_pkg::PSQ_IDLE;
                        end
                    end
                end
            end
            default: begin
                next_state = psq_pkg::PSQ_IDLE;
            end
        endcase
        // Fetch stage: a stalled word stays until the buffer takes it
        next_fetch_valid = issue ? 1'b1 : (fetch_if.ready ? 1'b0 : fetch_valid);
        next_fetch_data = issue ? pat_mem[pat_addr] : fetch_data;
    end

    // Sequencer registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= psq_pkg::PSQ_IDLE;
            seq_idx <= psq_pkg::SEQ_FIRST;
            pat_addr <= '0;
            rep_cnt <= '0;
            fetch_valid <= 1'b0;
            fetch_data <= '0;
        end else begin
            state <= next_state;
            seq_idx <= next_seq_idx;
            pat_addr <= next_pat_addr;
            rep_cnt <= next_rep_cnt;
            fetch_valid <= next_fetch_valid;
            fetch_data <= next_fetch_data;
        end
    end

    // Buffer hookup
    assign fetch_if.valid = fetch_valid;
    assign fetch_if.data = fetch_data;
    // one new word per slice run
    assign play_if.ready = tick && (shift_left == '0);

    psq_buf2 buf_u (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_p(fetch_if),
        .out_p(play_if)
    );

    always_comb begin
        next_shift_reg = shift_reg;
        next_shift_left = shift_left;
        next_col = col;
        next_col_live = col_live;
        if (tick) begin
            if (shift_left != '0) begin
                // Next slice of the held word
                next_col = shift_reg[CH_MAX-1:0];
                next_shift_reg = shift_reg >> CH_MAX;
                next_shift_left = shift_left - SHL_W'(1);
                next_col_live = 1'b1;
            end else if (play_if.valid) begin
                // Load a fresh word
                next_col = play_if.data[CH_MAX-1:0];
                next_shift_reg = play_if.data >> CH_MAX;
                next_shift_left = SHL_W'(psq_pkg::SER - 1);
                next_col_live = 1'b1;
            end else begin
                // Nothing left: outputs go low
                next_col = '0;
                next_col_live = 1'b0;
            end
        end
    end

    // Serialiser registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            shift_reg <= '0;
            shift_left <= '0;
            col <= '0;
            col_live <= 1'b0;
        end else begin
            shift_reg <= next_shift_reg;
            shift_left <= next_shift_left;
            col <= next_col;
            col_live <= next_col_live;
        end
    end

    assign pods_on = (pod_count == 2'h0) ? psq_pkg::POD_ONE : pod_count;

    // Per channel pod mask and lane delay
    for (genvar c = 0; c < CH_MAX; c++) begin : g_ch
        localparam int POD = c / POD_CH; // Pod of this channel
        localparam int LANE = c % POD_CH; // Lane within pod
        assign col_m[c] = col[c] && (2'(POD) < pods_on);
        if ((LANE >= psq_pkg::DLY_CH_LO) && (LANE <= psq_pkg::DLY_CH_HI)) begin : g_dly
            logic [DLY_TAPS-1:0] line, next_line; // Older column bits
            logic [DLY_TAPS:0] taps; // Tap zero is undelayed
            logic [DLY_W-1:0] tap_req; // Requested taps
            logic [DLY_W-1:0] tap; // Taps, clamped to longest delay
            assign tap_req = dly_sel[POD * DLY_N + LANE - psq_pkg::DLY_CH_LO];
            assign tap = (tap_req > DLY_W'(DLY_TAPS)) ? DLY_W'(DLY_TAPS) : tap_req;
            assign taps = {line, col_m[c]};
            assign next_pod_out[c] = taps[tap];
            // Delay line next value
            always_comb begin
                next_line = {line[DLY_TAPS-2:0], col_m[c]};
            end
            // Delay line register
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    line <= '0;
                end else begin
                    line <= next_line;
                end
            end
        end else begin : g_dir
            // Undelayed lane
            assign next_pod_out[c] = col_m[c];
        end
    end

    // Output registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pod_out <= '0;
            running <= 1'b0;
        end else begin
            pod_out <= next_pod_out;
            running <= busy;
        end
    end

    // Armed with no trigger and no stop
    sequence s_armed_wait;
        (state == psq_pkg::PSQ_ARM) && !trig_hit && !stop;
    endsequence

    // Armed and the chosen slope arrives
    sequence s_armed_hit;
        (state == psq_pkg::PSQ_ARM) && trig_hit && !stop;
    endsequence

    // Last word of last entry fetched in continuous mode
    sequence s_list_wrap;
        issue && !stop && at_end && rep_done && list_end && continuous;
    endsequence

    AST_ARM_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_armed_wait |=> (state == psq_pkg::PSQ_ARM)) else $error("Armed sequencer left early");

    AST_ARM_NO_TICK: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state == psq_pkg::PSQ_ARM) |-> !tick) else $error("Point clock ran while armed");

    AST_TRIG_RUN: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_armed_hit |=> (state == psq_pkg::PSQ_RUN)) else $error("Trigger did not start run");

    AST_DIV_GAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (tick && (div_ratio > 32'h1)) |=> !tick) else $error("Divided ticks too close");

    AST_REP_STAY: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (issue && !stop && at_end && !rep_done) |=> (seq_idx == $past(seq_idx)))
        else $error("Entry advanced before repeats done");

    AST_WRAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_list_wrap |=> ((seq_idx == psq_pkg::SEQ_FIRST) && (state == psq_pkg::PSQ_RUN)))
        else $error("Continuous run did not wrap");

    AST_SHIFT_STEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (tick && (shift_left != '0)) |=> (shift_left == ($past(shift_left) - SHL_W'(1))))
        else $error("Serialiser skipped a slice");

    AST_ONE_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (tick && (shift_left == '0) && play_if.valid)
        |=> (col_live && (shift_left == SHL_W'(psq_pkg::SER - 1))))
        else $error("Offered word not loaded");

    AST_POD_MASK: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pod_count == psq_pkg::POD_ONE) [*6] |-> (pod_out[CH_MAX-1:POD_CH] == '0))
        else $error("Unfitted pod driven");
endmodule
`default_nettype wire

// ==== testbench/psq_pod_model.sv ====
// Pod model counting cycles where every channel drives high
`timescale 1ns/1ps
`default_nettype none
module psq_pod_model (
    input wire logic sys_clk,
    input wire logic [psq_pkg::CH_MAX-1:0] pod_in,
    output int high_cnt,
    output int one_cnt,
    output int two_cnt
);
    // Only the first pod high, or only the first two
    localparam logic [psq_pkg::CH_MAX-1:0] ONE_POD = {psq_pkg::POD_CH{1'b1}};
    localparam logic [psq_pkg::CH_MAX-1:0] TWO_PODS = {(2 * psq_pkg::POD_CH){1'b1}};
    initial begin
        high_cnt = 0;
        one_cnt = 0;
        two_cnt = 0;
    end
    // Count cycles with all, one or two pods high
    always @(posedge sys_clk) begin
        if (&pod_in === 1'b1)
            high_cnt <= high_cnt + 1;
        if (pod_in === ONE_POD)
            one_cnt <= one_cnt + 1;
        if (pod_in === TWO_PODS)
            two_cnt <= two_cnt + 1;
    end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Testbench for the pattern sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 0, sys_rst = 1, start = 0, stop = 0, continuous = 0, pll_on = 1;
    logic trig_pin = 0, trig_fall = 0, pat_we = 0, seq_we = 0, running;
    logic [psq_pkg::DIV_W-1:0] div_ratio = 32'h1;
    logic [1:0] pod_count = psq_pkg::POD_THREE;
    logic [psq_pkg::DLY_W-1:0] dly_sel [psq_pkg::PODS_MAX*4] = '{default: 3'h0};
    logic [psq_pkg::PAT_AW-1:0] pat_waddr = 8'h0;
    logic [psq_pkg::WORD_W-1:0] pat_wdata = '1;
    logic [psq_pkg::SEQ_AW-1:0] seq_waddr = 4'h0;
    psq_pkg::psq_entry_t seq_wdata = '{8'h0, 8'h0, 16'h2, 1'b1};
    logic [psq_pkg::CH_MAX-1:0] pod_out;
    int num_errors = 0, n_tests = 0, high_cnt, one_cnt, two_cnt, c0, c1;
    localparam int NPTS = 2 * psq_pkg::SER; // Two passes of a one-word segment
    always #2.5 sys_clk = ~sys_clk;
    psq_top dut_u (.sys_clk, .sys_rst, .start, .stop, .continuous, .pll_on, .trig_pin,
        .trig_fall, .div_ratio, .pod_count, .dly_sel, .pat_we, .pat_waddr, .pat_wdata,
        .seq_we, .seq_waddr, .seq_wdata, .pod_out, .running);
    psq_pod_model pod_u (.sys_clk(sys_clk), .pod_in(pod_out), .high_cnt(high_cnt),
        .one_cnt(one_cnt), .two_cnt(two_cnt));
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic check_cnt(input int got, input int exp, input string msg);
        n_tests++;
        if (got != exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %0d expected %0d", $time, msg, got, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Bounded wait on the run flag
    task automatic wait_run(input logic v);
        for (int i = 0; i < 400 && running !== v; i++) @(negedge sys_clk);
        check(running === v, "run flag timeout");
        if (running !== v) final_report();
    endtask
    // One pass: start pulse, run flag up, run flag down, outputs settle
    task automatic run_once();
        @(posedge sys_clk) start <= 1;
        @(posedge sys_clk) start <= 0;
        wait_run(1'b1);
        wait_run(1'b0);
        repeat (8) @(posedge sys_clk);
    endtask
    // Single pass: one point per clock, two passes of one word
    task automatic t_run();
        c0 = high_cnt;
        run_once();
        check_cnt(high_cnt - c0, NPTS, "points per run");
        $display("t_run done");
    endtask
    // Divided point rate stretches every point
    task automatic t_div();
        @(posedge sys_clk) div_ratio <= 32'h3;
        c0 = high_cnt;
        run_once();
        check_cnt(high_cnt - c0, NPTS * 3, "divided point rate");
        @(posedge sys_clk) div_ratio <= 32'h1;
        $display("t_div done");
    endtask
    // One, two and three pods fitted
    task automatic t_pods();
        @(posedge sys_clk) pod_count <= psq_pkg::POD_ONE;
        c0 = high_cnt;
        c1 = one_cnt;
        run_once();
        check_cnt(one_cnt - c1, NPTS, "one pod points");
        check_cnt(high_cnt - c0, 0, "unfitted pods driven");
        @(posedge sys_clk) pod_count <= psq_pkg::POD_TWO;
        c1 = two_cnt;
        run_once();
        check_cnt(two_cnt - c1, NPTS, "two pod points");
        @(posedge sys_clk) pod_count <= psq_pkg::POD_THREE;
        c0 = high_cnt;
        run_once();
        check_cnt(high_cnt - c0, NPTS, "three pod points");
        $display("t_pods done");
    endtask
    // Delayed lanes shorten the all-high overlap
    task automatic t_dly();
        @(posedge sys_clk) dly_sel <= '{default: 3'h2};
        c0 = high_cnt;
        run_once();
        check_cnt(high_cnt - c0, NPTS - 2, "ten ns delay");
        @(posedge sys_clk) dly_sel <= '{default: 3'h7};
        c0 = high_cnt;
        run_once();
        check_cnt(high_cnt - c0, NPTS - psq_pkg::DLY_TAPS, "delay clamp");
        @(posedge sys_clk) dly_sel <= '{default: 3'h0};
        $display("t_dly done");
    endtask
    // Falling slope releases an armed single run
    task automatic t_trig_fall();
        @(posedge sys_clk) trig_fall <= 1;
        pll_on <= 0;
        continuous <= 0;
        start <= 1;
        @(posedge sys_clk) start <= 0;
        c0 = high_cnt;
        repeat (50) @(posedge sys_clk);
        check_cnt(high_cnt - c0, 0, "output before falling slope");
        @(posedge sys_clk) trig_pin <= 0;
        wait_run(1'b0);
        repeat (8) @(posedge sys_clk);
        check_cnt(high_cnt - c0, NPTS, "falling slope run");
        @(posedge sys_clk) trig_fall <= 0;
        pll_on <= 1;
        $display("t_trig_fall done");
    endtask
    // Unlocked clock idles until the trigger slope
    task automatic t_trig();
        @(posedge sys_clk) pll_on <= 0;
        continuous <= 1;
        start <= 1;
        @(posedge sys_clk) start <= 0;
        wait_run(1'b1);
        c0 = high_cnt;
        repeat (50) @(posedge sys_clk);
        check(high_cnt == c0, "output before trigger");
        @(posedge sys_clk) trig_pin <= 1;
        repeat (200) @(posedge sys_clk);
        check(high_cnt > c0, "no output after trigger");
        check(running === 1'b1, "continuous run ended");
        @(posedge sys_clk) stop <= 1;
        @(posedge sys_clk) stop <= 0;
        wait_run(1'b0);
        @(posedge sys_clk) continuous <= 0;
        $display("t_trig done");
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 0;
        pat_we <= 1;
        seq_we <= 1;
        @(posedge sys_clk) pat_we <= 0;
        seq_we <= 0;
        t_run();
        t_div();
        t_pods();
        t_dly();
        t_trig();
        t_trig_fall();
        final_report();
    end
endmodule
`default_nettype wire
